// ===== core/lin_config_and_register_map.sv
// special function register front end of the lin controller
`timescale 1ns/100ps
module lin_config_and_register_map (
    input wire logic clk, // system clock, 125 MHz
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable, freezes state when low
    input wire logic [7:0] sfr_addr, // special function register address
    input wire logic sfr_wr, // write strobe, one cycle
    input wire logic sfr_rd, // read strobe, one cycle
    input wire logic [7:0] sfr_wdata, // write data
    output logic [7:0] sfr_rdata, // read data, registered
    output logic controller_enable_bit, // controller enabled
    output logic master_mode, // master role selected
    output logic auto_baud_active, // auto baud in effect
    output logic [7:0] frame_control, // control register toward engine
    output logic stop_pulse, // one-cycle stop request
    output logic clear_int_pulse, // one-cycle interrupt clear
    output logic clear_err_pulse, // one-cycle error clear
    output logic [7:0] frame_length_checksum, // size register
    output logic [7:0] baud_divider_low, // divider low byte
    output logic [7:0] baud_multiplier_prescale, // multiplier register
    output logic [7:0] frame_identifier, // identifier register
    output logic [63:0] data_bytes, // data bytes one to eight
    input wire logic [7:0] frame_status, // status from engine
    input wire logic [7:0] error_flags, // errors from engine
    input wire logic eng_clr_data_ack, // engine clears ack bit
    input wire logic eng_clr_wake_req, // engine clears wakeup request
    input wire logic eng_clr_start_req, // engine clears start request
    input wire logic eng_data_we, // engine writes a data byte
    input wire logic [2:0] eng_data_sel, // engine data byte select
    input wire logic [7:0] eng_data_wdata // engine data byte
);
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] index;
        logic [7:0] ctrl;
        logic [7:0] size;
        logic [7:0] div;
        logic [7:0] mul;
        logic [7:0] id;
        logic [7:0] rdata;
        logic stop;
        logic clr_int;
        logic clr_err;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic [7:0] access_mask;
    logic [7:0] win_rd;
    logic [7:0] ind_val;
    logic win_wr;
    logic win_rd_hit;
    logic data_sel;
    logic [7:0] wmasked;

    lin_mode_filter u_filter (
        .index(st_reg.index),
        .master(st_reg.cfg[lin_regs_pkg::CFG_MASTER_BIT]),
        .access_mask(access_mask)
    );

    assign win_wr = sfr_wr && sfr_addr == lin_regs_pkg::WINDOW_ADDR;
    assign win_rd_hit = sfr_rd && sfr_addr == lin_regs_pkg::WINDOW_ADDR;
    assign data_sel = st_reg.index <= lin_regs_pkg::IDX_DATA_LAST;

    lin_data_buffer u_buf (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .sw_we(win_wr && data_sel),
        .sw_sel(st_reg.index[2:0]),
        .sw_wdata(sfr_wdata),
        .eng_we(eng_data_we),
        .eng_sel(eng_data_sel),
        .eng_wdata(eng_data_wdata),
        .bytes_flat(data_bytes)
    );

    // indirect read value before role masking
    always_comb begin
        unique case (st_reg.index)
            lin_regs_pkg::IDX_CONTROL: ind_val = st_reg.ctrl & ~lin_regs_pkg::CTRL_WONLY_MASK;
            lin_regs_pkg::IDX_STATUS: ind_val = frame_status;
            lin_regs_pkg::IDX_ERROR: ind_val = error_flags & lin_regs_pkg::ERR_MASK;
            lin_regs_pkg::IDX_SIZE: ind_val = st_reg.size;
            lin_regs_pkg::IDX_DIV: ind_val = st_reg.div;
            lin_regs_pkg::IDX_MUL: ind_val = st_reg.mul;
            lin_regs_pkg::IDX_ID: ind_val = st_reg.id;
            default: ind_val = data_sel ? data_bytes[st_reg.index[2:0]*8 +: 8] : 8'h00;
        endcase
        win_rd = ind_val & access_mask;
    end

    assign wmasked = sfr_wdata & access_mask;

    always_comb begin
        st_next = st_reg;
        st_next.stop = 1'b0;
        st_next.clr_int = 1'b0;
        st_next.clr_err = 1'b0;
        // engine clears of self-clearing bits
        if (eng_clr_data_ack) begin
            st_next.ctrl[lin_regs_pkg::CTRL_ACK_BIT] = 1'b0;
        end
        if (eng_clr_wake_req) begin
            st_next.ctrl[lin_regs_pkg::CTRL_WAKE_BIT] = 1'b0;
        end
        if (eng_clr_start_req) begin
            st_next.ctrl[lin_regs_pkg::CTRL_START_BIT] = 1'b0;
        end
        if (sfr_wr && sfr_addr == lin_regs_pkg::CFG_ADDR) begin
            st_next.cfg = sfr_wdata & lin_regs_pkg::CFG_WMASK;
        end
        if (sfr_wr && sfr_addr == lin_regs_pkg::INDEX_ADDR) begin
            st_next.index = sfr_wdata;
        end
        if (win_wr) begin
            unique case (st_reg.index)
                lin_regs_pkg::IDX_CONTROL: begin
                    // software set wins over engine clear; restricted bits keep value
                    st_next.ctrl = (st_next.ctrl & ~access_mask) | (wmasked & ~lin_regs_pkg::CTRL_WONLY_MASK);
                    st_next.stop = wmasked[lin_regs_pkg::CTRL_STOP_BIT];
                    st_next.clr_int = wmasked[lin_regs_pkg::CTRL_CLR_INT_BIT];
                    st_next.clr_err = wmasked[lin_regs_pkg::CTRL_CLR_ERR_BIT];
                end
                lin_regs_pkg::IDX_SIZE: st_next.size = sfr_wdata & lin_regs_pkg::SIZE_MASK;
                lin_regs_pkg::IDX_DIV: st_next.div = sfr_wdata;
                lin_regs_pkg::IDX_MUL: st_next.mul = sfr_wdata;
                lin_regs_pkg::IDX_ID: st_next.id = sfr_wdata & lin_regs_pkg::ID_MASK;
                default: st_next.index = st_reg.index;
            endcase
        end
        if (sfr_rd) begin
            if (sfr_addr == lin_regs_pkg::CFG_ADDR) begin
                st_next.rdata = st_reg.cfg;
            end else if (sfr_addr == lin_regs_pkg::INDEX_ADDR) begin
                st_next.rdata = st_reg.index;
            end else if (win_rd_hit) begin
                st_next.rdata = win_rd;
            end else begin
                st_next.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.cfg <= lin_regs_pkg::CFG_RESET;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign sfr_rdata = st_reg.rdata;
    assign controller_enable_bit = st_reg.cfg[lin_regs_pkg::CFG_EN_BIT];
    assign master_mode = st_reg.cfg[lin_regs_pkg::CFG_MASTER_BIT];
    assign auto_baud_active = st_reg.cfg[lin_regs_pkg::CFG_AUTO_BAUD_BIT] && !master_mode;
    assign frame_control = st_reg.ctrl;
    assign stop_pulse = st_reg.stop;
    assign clear_int_pulse = st_reg.clr_int;
    assign clear_err_pulse = st_reg.clr_err;
    assign frame_length_checksum = st_reg.size;
    assign baud_divider_low = st_reg.div;
    assign baud_multiplier_prescale = st_reg.mul;
    assign frame_identifier = st_reg.id;
endmodule : lin_config_and_register_map

// ===== core/lin_regs_pkg.sv
// constants for the lin controller register front end
// Overview of operation
// - config bit 7 enables the whole controller; zero disables it.
// - config bit 6 selects role: zero slave, one master.
// - config bit 5 picks manual (zero) or automatic (one) baud rate.
// - automatic baud bit has effect only in slave role; ignored as master.
// - config bits 4:0 read zero and ignore writes.
// - fifteen indirect byte registers at index 0x00 to 0x0E.
// - master-only bits are accessible only in master role.
// - slave-only bits accessible only in slave role; other bits always.
// - index register selects target; window register reads and writes it.
package lin_regs_pkg;
    localparam logic [7:0] CFG_ADDR = 8'hc9;
    localparam logic [7:0] INDEX_ADDR = 8'hd3;
    localparam logic [7:0] WINDOW_ADDR = 8'hd2;
    localparam logic [7:0] CFG_RESET = 8'h60;
    localparam logic [7:0] CFG_WMASK = 8'he0;
    localparam int CFG_EN_BIT = 7;
    localparam int CFG_MASTER_BIT = 6;
    localparam int CFG_AUTO_BAUD_BIT = 5;
    localparam logic [7:0] IDX_DATA_FIRST = 8'h00;
    localparam logic [7:0] IDX_DATA_LAST = 8'h07;
    localparam logic [7:0] IDX_CONTROL = 8'h08;
    localparam logic [7:0] IDX_STATUS = 8'h09;
    localparam logic [7:0] IDX_ERROR = 8'h0a;
    localparam logic [7:0] IDX_SIZE = 8'h0b;
    localparam logic [7:0] IDX_DIV = 8'h0c;
    localparam logic [7:0] IDX_MUL = 8'h0d;
    localparam logic [7:0] IDX_ID = 8'h0e;
    localparam logic [7:0] REG_RESET = 8'h00;
    // bit positions inside the control register
    localparam int CTRL_STOP_BIT = 7;
    localparam int CTRL_ACK_BIT = 4;
    localparam int CTRL_CLR_INT_BIT = 3;
    localparam int CTRL_CLR_ERR_BIT = 2;
    localparam int CTRL_WAKE_BIT = 1;
    localparam int CTRL_START_BIT = 0;
    // mode-restricted control masks, then control write-only mask, then status and error mode masks, then field masks
    localparam logic [7:0] CTRL_SLAVE_MASK = 8'hd0;
    localparam logic [7:0] CTRL_MASTER_MASK = 8'h01;
    localparam logic [7:0] CTRL_WONLY_MASK = 8'h8c;
    localparam logic [7:0] STAT_SLAVE_MASK = 8'h30;
    localparam logic [7:0] ERR_SLAVE_MASK = 8'h18;
    localparam logic [7:0] SIZE_MASK = 8'h8f;
    localparam logic [7:0] ID_MASK = 8'h3f;
    localparam logic [7:0] ERR_MASK = 8'h1f;
endpackage : lin_regs_pkg

// ===== core/lin_mode_filter.sv
// role-dependent access mask for one indirect register
`timescale 1ns/100ps
module lin_mode_filter (
    input wire logic [7:0] index, // indirect register index
    input wire logic master, // master role selected
    output logic [7:0] access_mask // bits reachable in current role
);
    logic [7:0] slave_bits;
    logic [7:0] master_bits;
    always_comb begin
        slave_bits = 8'h00;
        master_bits = 8'h00;
        if (index == lin_regs_pkg::IDX_CONTROL) begin
            slave_bits = lin_regs_pkg::CTRL_SLAVE_MASK;
            master_bits = lin_regs_pkg::CTRL_MASTER_MASK;
        end else if (index == lin_regs_pkg::IDX_STATUS) begin
            slave_bits = lin_regs_pkg::STAT_SLAVE_MASK;
        end else if (index == lin_regs_pkg::IDX_ERROR) begin
            slave_bits = lin_regs_pkg::ERR_SLAVE_MASK;
        end
        access_mask = ~(master ? slave_bits : master_bits);
    end
endmodule : lin_mode_filter

// ===== core/lin_data_buffer.sv
// eight-byte frame data buffer shared by software and frame engine
`timescale 1ns/100ps
module lin_data_buffer (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic sw_we, // software write strobe
    input wire logic [2:0] sw_sel, // software byte select
    input wire logic [7:0] sw_wdata, // software write data
    input wire logic eng_we, // engine write strobe
    input wire logic [2:0] eng_sel, // engine byte select
    input wire logic [7:0] eng_wdata, // engine write data
    output logic [63:0] bytes_flat // all eight bytes, byte 1 lowest
);
    typedef struct packed {
        logic [7:0][7:0] mem;
    } buf_s;
    buf_s buf_reg;
    buf_s buf_next;
    always_comb begin
        buf_next = buf_reg;
        for (int i = 0; i < 8; i++) begin
            if (eng_we && eng_sel == 3'(i)) begin
                buf_next.mem[i] = eng_wdata;
            end
            // software wins a same-byte collision
            if (sw_we && sw_sel == 3'(i)) begin
                buf_next.mem[i] = sw_wdata;
            end
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_reg <= '0;
        end else if (ce) begin
            buf_reg <= buf_next;
        end
    end
    assign bytes_flat = buf_reg.mem;
endmodule : lin_data_buffer

// ===== tb/lin_map_checker.sv
// port assertions for the lin register front end
`timescale 1ns/100ps
module lin_map_checker (
    input wire logic clk, // clock
    input wire logic nrst, // reset
    input wire logic ce, // clock enable
    input wire logic [7:0] sfr_addr, // address
    input wire logic sfr_wr, // write
    input wire logic sfr_rd, // read
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic [7:0] sfr_rdata, // read data
    input wire logic controller_enable_bit, // enable
    input wire logic master_mode, // role
    input wire logic auto_baud_active, // auto baud
    input wire logic stop_pulse // stop request
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic cfg_wr;
    logic cfg_rd;
    logic odd_rd;
    assign cfg_wr = ce && sfr_wr && sfr_addr == lin_regs_pkg::CFG_ADDR;
    assign cfg_rd = ce && sfr_rd && sfr_addr == lin_regs_pkg::CFG_ADDR;
    assign odd_rd = ce && sfr_rd && !(sfr_addr inside {8'hc9, 8'hd2, 8'hd3});
    a_cfg_enable: assert property (cfg_wr |=> controller_enable_bit == $past(sfr_wdata[7]))
        else $error("enable bit not taken");
    a_cfg_role: assert property (cfg_wr ##1 1'b1 |-> master_mode == $past(sfr_wdata[6]))
        else $error("role bit not taken");
    a_baud_slave: assert property (cfg_wr && !sfr_wdata[6] |=> auto_baud_active == $past(sfr_wdata[5]))
        else $error("auto baud not taken");
    a_baud_master: assert property (master_mode |-> !auto_baud_active)
        else $error("auto baud active as master");
    a_cfg_unused: assert property (cfg_rd |=> sfr_rdata[4:0] == 5'h0)
        else $error("unused bits not zero");
    a_unmapped_zero: assert property (odd_rd |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!(ce && sfr_rd) |=> $stable(sfr_rdata))
        else $error("read data moved");
    a_stop_slave: assert property (stop_pulse |-> !$past(master_mode))
        else $error("stop as master");
    c_slave_cfg: cover property (cfg_wr && !sfr_wdata[6]);
    c_stop: cover property (stop_pulse);
    c_odd_read: cover property (odd_rd);
endmodule : lin_map_checker
bind lin_config_and_register_map lin_map_checker lin_map_checker_inst (.clk, .nrst, .ce, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata, .controller_enable_bit, .master_mode, .auto_baud_active, .stop_pulse);

// ===== tb/sfr_host.sv
// processor side model issuing register accesses
`timescale 1ns/100ps
module sfr_host (
    input wire logic clk, // system clock
    input wire logic [7:0] sfr_rdata, // read data
    output logic [7:0] sfr_addr, // address
    output logic sfr_wr, // write strobe
    output logic sfr_rd, // read strobe
    output logic [7:0] sfr_wdata // write data
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end
    // one access, held for one edge; index then window selects the target
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= w;
        sfr_rd <= !w;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
        @(posedge clk);
        #1 q = sfr_rdata;
    endtask : acc
endmodule : sfr_host

// ===== tb/lin_config_and_register_map_tb_top.sv
// self-checking bench for the lin register front end
`timescale 1ns/100ps
module lin_config_and_register_map_tb_top;
    logic clk, nrst, ce, eng_data_we, controller_enable_bit, master_mode, auto_baud_active, stop_pulse, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, frame_status, error_flags, eng_data_wdata, v;
    logic [2:0] eng_data_sel;
    logic [63:0] data_bytes;
    logic [7:0] frame_control, frame_length_checksum, baud_divider_low, baud_multiplier_prescale, frame_identifier;
    logic clear_int_pulse, clear_err_pulse, eng_clr;
    int mismatches = 0;
    int checks_done = 0;
    int stop_seen = 0;
    int clr_int_seen = 0;
    int clr_err_seen = 0;
    lin_config_and_register_map lin_config_and_register_map_inst (.clk, .nrst, .ce, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata, .controller_enable_bit, .master_mode, .auto_baud_active, .frame_control,
        .stop_pulse, .clear_int_pulse, .clear_err_pulse, .frame_length_checksum, .baud_divider_low,
        .baud_multiplier_prescale, .frame_identifier, .data_bytes, .frame_status, .error_flags,
        .eng_clr_data_ack(eng_clr), .eng_clr_wake_req(eng_clr), .eng_clr_start_req(eng_clr), .eng_data_we,
        .eng_data_sel, .eng_data_wdata);
    // pulses last one cycle, so count them as they pass
    always @(posedge clk) begin
        stop_seen <= stop_seen + int'(stop_pulse === 1'b1);
        clr_int_seen <= clr_int_seen + int'(clear_int_pulse === 1'b1);
        clr_err_seen <= clr_err_seen + int'(clear_err_pulse === 1'b1);
    end
    sfr_host host_inst (.clk, .sfr_rdata, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
        checks_done++;
        if (got !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_inst.acc(1'b1, a, d, v);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
        host_inst.acc(1'b0, a, 8'h00, v);
        chk(what, e, v);
    endtask : rdc
    // writes all ones to each index 0x00 to 0x0F and reads back through the window
    task automatic sweep(input logic m);
        logic [7:0] e;
        for (int i = 0; i < 16; i++) begin
            case (i)
                8: e = m ? 8'h23 : 8'h72;
                9: e = m ? 8'hcf : 8'hff;
                10: e = m ? 8'h07 : 8'h1f;
                11: e = 8'h8f;
                14: e = 8'h3f;
                15: e = 8'h00;
                default: e = 8'hff;
            endcase
            wr(8'hd3, 8'(i));
            wr(8'hd2, 8'hff);
            rdc(8'hd2, e, "window");
        end
    endtask : sweep
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        frame_status = 8'hff;
        error_flags = 8'hff;
        eng_data_we = 1'b0;
        eng_clr = 1'b0;
        eng_data_sel = 3'h7;
        eng_data_wdata = 8'h5a;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdc(8'hc9, 8'h60, "cfg reset");
        chk("flags", 8'h40, {controller_enable_bit, master_mode, auto_baud_active, 5'h00});
        wr(8'hc9, 8'hff);
        rdc(8'hc9, 8'he0, "cfg masked");
        chk("flags", 8'hc0, {controller_enable_bit, master_mode, auto_baud_active, 5'h00});
        sweep(1'b1);
        chk("ctrl out", 8'h23, frame_control);
        chk("size out", 8'h8f, frame_length_checksum);
        chk("div out", 8'hff, baud_divider_low);
        chk("mul out", 8'hff, baud_multiplier_prescale);
        chk("id out", 8'h3f, frame_identifier);
        chk("byte one", 8'hff, data_bytes[7:0]);
        wr(8'hc9, 8'h20);
        rdc(8'hc9, 8'h20, "cfg slave");
        chk("flags", 8'h20, {controller_enable_bit, master_mode, auto_baud_active, 5'h00});
        sweep(1'b0);
        chk("ctrl out", 8'h73, frame_control);
        wr(8'hd3, 8'h08);
        wr(8'hd2, 8'h00);
        wr(8'hc9, 8'h40);
        rdc(8'hd2, 8'h01, "kept start");
        chk("ctrl kept", 8'h01, frame_control);
        rdc(8'h00, 8'h00, "unmapped");
        @(posedge clk);
        eng_data_we <= 1'b1;
        eng_clr <= 1'b1;
        @(posedge clk);
        eng_data_we <= 1'b0;
        eng_clr <= 1'b0;
        @(posedge clk);
        #1 chk("engine byte", 8'h5a, data_bytes[63:56]);
        chk("ctrl cleared", 8'h00, frame_control);
        chk("stop pulses", 8'h01, 8'(stop_seen));
        chk("int clears", 8'h02, 8'(clr_int_seen));
        chk("err clears", 8'h02, 8'(clr_err_seen));
        @(posedge clk);
        ce <= 1'b0;
        wr(8'hc9, 8'h80);
        @(posedge clk);
        ce <= 1'b1;
        rdc(8'hc9, 8'h40, "cfg frozen");
        close_out();
    end
endmodule : lin_config_and_register_map_tb_top
